// file: dgsc_pkg.sv
// constants, field layout and timing for the dual gain serial control block
// assumes nothing; imported by every design file of the block
package dgsc_pkg;
    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned ZC_TIMEOUT_MS = 24;
    localparam int unsigned ZC_TIMEOUT_CYC =
        (CLK_HZ / 1000) * ZC_TIMEOUT_MS;
    localparam int          WORD_W       = 32;
    localparam int          SECT_W       = 16;
    localparam int          STEP_W       = 5;
    localparam int          BCNT_W       = 6;
    localparam int          TMR_W        = 20;
    // section layout: [4:0] step code, [8] aux level,
    // [12] aux zc mode, [13] step zc mode, others ignored
    localparam int          STEP_LSB     = 0;
    localparam int          AUX_BIT      = 8;
    localparam int          AUX_MD_BIT   = 12;
    localparam int          STEP_MD_BIT  = 13;
    localparam logic [4:0]  STEP_MAX     = 5'h11;
    localparam logic [4:0]  STEP_RST     = 5'h00;
    localparam logic [1:0]  MODE_RST     = 2'h0;
    localparam logic [TMR_W-1:0] TMR_ONE = 20'h00001;
    localparam logic [TMR_W-1:0] TMR_ZERO = 20'h00000;
    localparam logic [BCNT_W-1:0] BCNT_ONE = 6'h01;
    localparam logic [BCNT_W-1:0] BCNT_ZERO = 6'h00;
endpackage

// file: dgsc_sync.sv
// two flip-flop synchroniser for one level
// assumes d is asynchronous to clk
`timescale 1ns/10ps
`default_nettype none
module dgsc_sync
    import dgsc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output var  logic q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } dgsc_sync_t;
    dgsc_sync_t st_ff;
    dgsc_sync_t nxt_st;

    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.s2;
endmodule
`default_nettype wire

// file: dgsc_link.sv
// serial shifter on the master's serial clock
// assumes sclk runs only while cs_n is low; cs_n low also enables shifting
`timescale 1ns/10ps
`default_nettype none
module dgsc_link
    import dgsc_pkg::*;
(
    input  wire logic              sclk,
    input  wire logic              cs_n,
    input  wire logic              sdi,
    input  wire logic              block,
    output var  logic [WORD_W-1:0] shift_word,
    output var  logic              sdo,
    output var  logic              sdo_oe
);
    typedef struct packed {
        logic [WORD_W-1:0] sh;
    } dgsc_lnk_t;
    typedef struct packed {
        logic out;
    } dgsc_lno_t;
    dgsc_lnk_t st_ff;
    dgsc_lnk_t nxt_st;
    dgsc_lno_t ost_ff;
    dgsc_lno_t nxt_ost;

    always_comb begin
        nxt_st = st_ff;
        if (!cs_n && !block) begin
            nxt_st.sh = {st_ff.sh[WORD_W-2:0], sdi};
        end
    end

    always_comb begin
        nxt_ost     = ost_ff;
        nxt_ost.out = st_ff.sh[WORD_W-1];
    end

    // shift register keeps its contents across frames; words are
    // captured in the system domain only after cs_n rises
    always_ff @(posedge sclk) begin
        st_ff <= nxt_st;
    end

    always_ff @(negedge sclk) begin
        ost_ff <= nxt_ost;
    end

    assign shift_word = st_ff.sh;
    assign sdo        = ost_ff.out;
    assign sdo_oe     = !cs_n;
endmodule
`default_nettype wire

// file: dgsc_top.sv
// two-channel stepped gain control behind a daisy-chainable serial port
// assumes clk at 25 MHz, sclk from the master, zero-cross levels async
`timescale 1ns/10ps
`default_nettype none

// How it works
// - each channel has separate zero-cross modes for aux output and step
// - after reset all zero-cross mode bits are cleared
// - step code k gives 3k dB, valid 0 to 17
// - step mode 0 applies now, mode 1 waits for zero cross
// - aux mode 0 applies now, mode 1 waits for zero cross
// - serial output passes shifted data to the next device
// - shifted word taken into settings on select rising edge
// - serial activity ignored while power-up is in progress
// - reset puts both channels at step code zero
// - select low frames; sample rising, drive falling, float when high
// - step codes 18 to 31 are ignored, gain kept
// - pending update lands at zero window or 24 ms timeout
module dgsc_top
    import dgsc_pkg::*;
#(
    parameter logic [TMR_W-1:0] ZC_TIMEOUT = TMR_W'(ZC_TIMEOUT_CYC)
)
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              sclk,
    input  wire logic              cs_n,
    input  wire logic              sdi,
    input  wire logic              powerup_busy,
    input  wire logic [1:0]        zero_cross,
    output var  logic              sdo,
    output var  logic              sdo_oe,
    output var  logic [STEP_W-1:0] amp_step_ch1,
    output var  logic [STEP_W-1:0] amp_step_ch2,
    output var  logic [1:0]        aux_output,
    output var  logic [1:0]        busy
);
    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef struct packed {
        logic [STEP_W-1:0] step;
        logic              aux;
        logic              aux_md;
        logic              step_md;
        logic [STEP_W-1:0] pend_step;
        logic              pend_aux;
        logic              step_pend;
        logic              aux_pend;
        logic [TMR_W-1:0]  tmr;
    } dgsc_ch_t;

    typedef struct packed {
        logic              cs_d;
        dgsc_ch_t [1:0]    ch;
        logic [1:0]        busy;
    } dgsc_st_t;

    // -------------------------------------------------------------
    // crossings and serial link
    // -------------------------------------------------------------
    logic              cs_s;
    logic              pu_s;
    logic [1:0]        zc_s;
    logic [WORD_W-1:0] shift_word;
    logic              lnk_sdo;
    logic              lnk_oe;

    dgsc_sync u_cs_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (cs_n),
        .q     (cs_s)
    );

    dgsc_sync u_pu_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (powerup_busy),
        .q     (pu_s)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_zc
            dgsc_sync u_zc_sync (
                .clk   (clk),
                .rst_n (rst_n),
                .d     (zero_cross[gi]),
                .q     (zc_s[gi])
            );
        end
    endgenerate

    dgsc_link u_link (
        .sclk       (sclk),
        .cs_n       (cs_n),
        .sdi        (sdi),
        .block      (powerup_busy),
        .shift_word (shift_word),
        .sdo        (lnk_sdo),
        .sdo_oe     (lnk_oe)
    );

    // the serial output is a link-side pin; it cannot be re-timed to
    // clk without breaking the falling-edge timing the master expects
    assign sdo    = lnk_sdo;
    assign sdo_oe = lnk_oe;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // codes above 17 undefined
    function automatic logic step_ok(input logic [STEP_W-1:0] c);
        step_ok = (c <= STEP_MAX);
    endfunction

    function automatic logic [SECT_W-1:0] sect(
        input logic [WORD_W-1:0] w,
        input int                n
    );
        // channel 1 arrived first, so sits in the upper half
        sect = (n == 0) ? w[WORD_W-1:SECT_W] : w[SECT_W-1:0];
    endfunction

    // -------------------------------------------------------------
    // settings
    // -------------------------------------------------------------
    dgsc_st_t st_ff;
    dgsc_st_t nxt_st;

    always_comb begin
        logic              rise;
        logic [SECT_W-1:0] s;
        logic [STEP_W-1:0] code;
        logic              land;
        rise = 1'b0;
        s    = '0;
        code = '0;
        land = 1'b0;
        nxt_st      = st_ff;
        nxt_st.cs_d = cs_s;
        rise = cs_s && !st_ff.cs_d && !pu_s;
        // shift_word is stable here: sclk is idle once cs_n is high
        // and the synchroniser delay covers the last rising edge
        for (int n = 0; n < 2; n++) begin
            land = zc_s[n] || (st_ff.ch[n].tmr == TMR_ONE);
            if (st_ff.ch[n].tmr != TMR_ZERO) begin
                nxt_st.ch[n].tmr = st_ff.ch[n].tmr - TMR_ONE;
            end
            if ((st_ff.ch[n].step_pend || st_ff.ch[n].aux_pend) && land) begin
                if (st_ff.ch[n].step_pend) begin
                    nxt_st.ch[n].step = st_ff.ch[n].pend_step;
                end
                if (st_ff.ch[n].aux_pend) begin
                    nxt_st.ch[n].aux = st_ff.ch[n].pend_aux;
                end
                nxt_st.ch[n].step_pend = 1'b0;
                nxt_st.ch[n].aux_pend  = 1'b0;
                nxt_st.ch[n].tmr       = TMR_ZERO;
            end
            if (rise) begin
                s    = sect(shift_word, n);
                code = s[STEP_LSB +: STEP_W];
                nxt_st.ch[n].aux_md  = s[AUX_MD_BIT];
                nxt_st.ch[n].step_md = s[STEP_MD_BIT];
                if (step_ok(code)) begin
                    // step now or at zero cross
                    if (s[STEP_MD_BIT]) begin
                        nxt_st.ch[n].pend_step = code;
                        nxt_st.ch[n].step_pend = 1'b1;
                    end else begin
                        nxt_st.ch[n].step      = code;
                        nxt_st.ch[n].step_pend = 1'b0;
                    end
                end
                // aux now or at zero cross
                if (s[AUX_MD_BIT]) begin
                    nxt_st.ch[n].pend_aux = s[AUX_BIT];
                    nxt_st.ch[n].aux_pend = 1'b1;
                end else begin
                    nxt_st.ch[n].aux      = s[AUX_BIT];
                    nxt_st.ch[n].aux_pend = 1'b0;
                end
                if (nxt_st.ch[n].step_pend || nxt_st.ch[n].aux_pend) begin
                    nxt_st.ch[n].tmr = ZC_TIMEOUT;
                end else begin
                    nxt_st.ch[n].tmr = TMR_ZERO;
                end
            end
            nxt_st.busy[n] = nxt_st.ch[n].step_pend;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff.cs_d <= 1'b1;
            st_ff.busy <= '0;
            for (int n = 0; n < 2; n++) begin
                st_ff.ch[n].step      <= STEP_RST;
                st_ff.ch[n].pend_step <= STEP_RST;
                {st_ff.ch[n].aux_md, st_ff.ch[n].step_md} <= MODE_RST;
                st_ff.ch[n].aux       <= 1'b0;
                st_ff.ch[n].pend_aux  <= 1'b0;
                st_ff.ch[n].step_pend <= 1'b0;
                st_ff.ch[n].aux_pend  <= 1'b0;
                st_ff.ch[n].tmr       <= TMR_ZERO;
            end
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign amp_step_ch1  = st_ff.ch[0].step;
    assign amp_step_ch2  = st_ff.ch[1].step;
    assign aux_output[0] = st_ff.ch[0].aux;
    assign aux_output[1] = st_ff.ch[1].aux;
    assign busy          = st_ff.busy;
endmodule
`default_nettype wire

// file: dgsc_top_assertions.sv
// port checker for dgsc_top
// assumes the clk domain ports only; bound to every dgsc_top
`timescale 1ns/10ps
`default_nettype none
module dgsc_top_assertions
    import dgsc_pkg::*;
#(
    parameter logic [TMR_W-1:0] ZC_TIMEOUT = TMR_W'(ZC_TIMEOUT_CYC)
)
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              cs_n,
    input wire logic              powerup_busy,
    input wire logic              sdo_oe,
    input wire logic [STEP_W-1:0] amp_step_ch1,
    input wire logic [STEP_W-1:0] amp_step_ch2,
    input wire logic [1:0]        aux_output,
    input wire logic [1:0]        busy
);
    // busy[0] stands at most one timeout past the latest select rise, plus
    // synchroniser and edge-detect latency; a counter keeps the bound
    // cheap where the timeout runs to hundreds of thousands of cycles
    localparam logic [TMR_W:0] BMAX    = {1'b0, ZC_TIMEOUT} + (TMR_W+1)'(8);
    localparam logic [TMR_W:0] CNT_ONE = (TMR_W+1)'(1);
    logic [TMR_W:0] bsy_cnt_ff;
    always_ff @(posedge clk) begin
        if (!rst_n || !busy[0] || !cs_n) begin
            bsy_cnt_ff <= '0;
        end else begin
            bsy_cnt_ff <= bsy_cnt_ff + CNT_ONE;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // --------
    // checks
    // --------
    chk_oe_follows_cs: assert property (sdo_oe == !cs_n)
        else $error("output enable not following select");
    chk_step1_range: assert property (amp_step_ch1 <= STEP_MAX)
        else $error("channel 1 step out of range");
    chk_step2_range: assert property (amp_step_ch2 <= STEP_MAX)
        else $error("channel 2 step out of range");
    chk_reset_clear: assert property (disable iff (1'h0)
        !rst_n |=> amp_step_ch1 == STEP_RST && amp_step_ch2 == STEP_RST
        && aux_output == 2'h0 && busy == 2'h0)
        else $error("settings not cleared by reset");
    chk_busy_holds: assert property ($rose(busy[0]) |->
        $stable(amp_step_ch1)) else $error("step moved while pending");
    chk_busy_bound: assert property (bsy_cnt_ff <= BMAX)
        else $error("pending update never landed");
    chk_step_cause: assert property ($changed(amp_step_ch1) |->
        $past(cs_n, 2) || $past(busy[0]))
        else $error("step changed without select rise");
    chk_pwr_quiet: assert property (powerup_busy &&
        $past(powerup_busy, 6) && !$past(busy[0], 6) |->
        $stable(amp_step_ch1)) else $error("update during power-up");
    cov_pending: cover property ($rose(busy[0]));
    cov_max_gain: cover property (amp_step_ch1 == STEP_MAX);
    cov_aux_on: cover property ($rose(aux_output[0]));
endmodule
bind dgsc_top dgsc_top_assertions #(.ZC_TIMEOUT(ZC_TIMEOUT))
    i_dgsc_top_assertions (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
    .powerup_busy(powerup_busy), .sdo_oe(sdo_oe),
    .amp_step_ch1(amp_step_ch1), .amp_step_ch2(amp_step_ch2),
    .aux_output(aux_output), .busy(busy));
`default_nettype wire

// file: dgsc_host.sv
// serial master model for dgsc_top
// assumes the device samples on sclk rise and drives sdo on sclk fall
`timescale 1ns/10ps
`default_nettype none
module dgsc_host (
    output var  logic        sclk,
    output var  logic        cs_n,
    output var  logic        sdi,
    input  wire logic        sdo,
    output var  logic [31:0] rx
);
    initial begin
        sclk = 1'h0;
        cs_n = 1'h1;
        sdi  = 1'h0;
        rx   = 32'h0;
    end
    task automatic send(input logic [31:0] w, input logic hold);
        cs_n = 1'h0;
        for (int i = 31; i >= 0; i--) begin
            sdi = w[i];
            #6 sclk = 1'h1;
            rx = {rx[30:0], sdo};
            #6 sclk = 1'h0;
        end
        // released data shows the inverse, never a stale bit
        #6 sdi = ~sdi;
        if (!hold) cs_n = 1'h1;
    endtask
endmodule
`default_nettype wire

// file: dgsc_top_tb.sv
// self-checking bench for dgsc_top
// assumes dgsc_host drives the serial pins; clk 25 MHz
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    miscompares++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module dgsc_top_tb
    import dgsc_pkg::*;
;
    logic              clk, rst_n, pwr, sdo, oe, sclk, cs_n, sdi;
    logic [1:0]        zc, aux, bsy, ea;
    logic [STEP_W-1:0] s1, s2, e1, e2, c2;
    logic [31:0]       rx, w;
    logic [15:0]       rnd = 16'h2605;
    logic [11:0]       q[$];
    logic [11:0]       prev = 12'h000;
    int                miscompares = 0;
    int                total_checks = 0;

    dgsc_top #(.ZC_TIMEOUT(TMR_W'(50))) i_dgsc_top (.clk(clk),
        .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .powerup_busy(pwr), .zero_cross(zc), .sdo(sdo), .sdo_oe(oe),
        .amp_step_ch1(s1), .amp_step_ch2(s2), .aux_output(aux), .busy(bsy));
    dgsc_host i_dgsc_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
        .rx(rx));

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [15:0] sect(input logic [4:0] st,
        input logic a, input logic am, input logic sm);
        return {2'h0, sm, am, 3'h0, a, 3'h0, st};
    endfunction
    // ---------
    // tasks; cmd and drain return just after a rising edge, end_of_test never returns
    // ---------
    task automatic cmd(input logic [15:0] a, input logic [15:0] b);
        rnd = lfsr(rnd);
        i_dgsc_host.send({a | (rnd & 16'hcee0), b | (~rnd & 16'hcee0)}, 1'h0);
        repeat (5) @(posedge clk);
        #1;
    endtask
    task automatic drain(input int n);
        for (int i = 0; i < n && q.size() > 0; i++) @(posedge clk);
        #1;
        if (q.size() > 0) begin
            miscompares++;
            end_of_test();
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // every change of the settings must match the oldest note
    always @(posedge clk) begin
        logic [11:0] e;
        #2;
        if (rst_n === 1'h1 && {s1, s2, aux} !== prev) begin
            e = (q.size() > 0) ? q.pop_front() : prev;
            `CHK({s1, s2, aux}, e)
            prev = {s1, s2, aux};
        end
    end
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    initial begin
        rst_n = 1'h0;
        pwr = 1'h0;
        zc = 2'h0;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'h1;
        repeat (3) @(posedge clk);
        #1 `CHK({s1, s2, aux, bsy}, 14'h0000)
        // maximum gain first, then sweep every code
        ea = 2'h1;
        q.push_back({STEP_MAX, STEP_MAX, ea});
        cmd(sect(5'h11, 1'h1, 1'h0, 1'h0), sect(5'h11, 1'h0, 1'h0, 1'h0));
        for (int k = 0; k < 32; k++) begin
            ea = ~ea;
            c2 = (k < 18) ? 5'(17 - k) : 5'(49 - k);
            if (k < 18) begin
                e1 = 5'(k);
                e2 = c2;
            end
            q.push_back({e1, e2, ea});
            cmd(sect(5'(k), ea[0], 1'h0, 1'h0), sect(c2, ea[1], 1'h0, 1'h0));
            drain(20);
        end
        // step now, aux at timeout, on one channel
        e1 = 5'h03;
        q.push_back({e1, e2, ea});
        ea[0] = ~ea[0];
        q.push_back({e1, e2, ea});
        cmd(sect(e1, ea[0], 1'h1, 1'h0), sect(e2, ea[1], 1'h0, 1'h0));
        drain(100);
        // newer pending command replaces the older one
        q.push_back({5'h09, e2, ea});
        cmd(sect(5'h07, ea[0], 1'h0, 1'h1), sect(e2, ea[1], 1'h0, 1'h0));
        `CHK(bsy[0], 1'h1)
        cmd(sect(5'h09, ea[0], 1'h0, 1'h1), sect(e2, ea[1], 1'h0, 1'h0));
        drain(150);
        `CHK(bsy[0], 1'h0)
        e1 = 5'h09;
        // zero window lands long before the timeout
        e2 = 5'h04;
        q.push_back({e1, e2, ea});
        cmd(sect(e1, ea[0], 1'h0, 1'h0), sect(e2, ea[1], 1'h0, 1'h1));
        `CHK(bsy[1], 1'h1)
        zc = 2'h2;
        drain(8);
        `CHK(bsy[1], 1'h0)
        zc = 2'h0;
        // two words under one select, only the last one taken
        rnd = lfsr(rnd);
        w = {rnd, ~rnd};
        e1 = 5'h02;
        e2 = 5'h06;
        ea = ~ea;
        q.push_back({e1, e2, ea});
        i_dgsc_host.send(w, 1'h1);
        `CHK(oe, 1'h1)
        cmd(sect(e1, ea[0], 1'h0, 1'h0), sect(e2, ea[1], 1'h0, 1'h0));
        `CHK(rx, w)
        `CHK(oe, 1'h0)
        drain(20);
        pwr = 1'h1;
        repeat (8) @(posedge clk);
        #1 cmd(sect(5'h0f, ~ea[0], 1'h0, 1'h0), sect(5'h0f, ~ea[1], 1'h0, 1'h0));
        repeat (20) @(posedge clk);
        #1 `CHK({s1, s2, aux}, {e1, e2, ea})
        pwr = 1'h0;
        drain(20);
        end_of_test();
    end
endmodule
`default_nettype wire
